/* File: hw/cmpr_pkg.sv */
// Constants and carrier types for the comparator register bank
package cmpr_pkg;
  localparam int CMPR_DATA_W = 8;
  localparam int CMPR_ADDR_W = 4;
  localparam int CMPR_NUM = 2;
  // Register offsets
  localparam logic [3:0] CMPR_OFF_CTRL_BASE = 4'h0;
  localparam logic [3:0] CMPR_OFF_MIRROR = 4'h2;
  localparam logic [3:0] CMPR_OFF_IRQ_STATUS = 4'h3;
  localparam logic [3:0] CMPR_OFF_IRQ_MASK = 4'h4;
  // Reset values
  localparam logic [7:0] CMPR_CTRL_RESET = 8'h00;
  localparam logic [7:0] CMPR_MIRROR_RESET = 8'h00;
  // Control field positions and write mask
  localparam int CMPR_BIT_RISE = 7;
  localparam int CMPR_BIT_FALL = 6;
  localparam int CMPR_POS_LSB = 4;
  localparam int CMPR_NEG_LSB = 0;
  localparam logic [7:0] CMPR_CTRL_WMASK = 8'hf7;
  // Positive input select codes
  localparam logic [1:0] CMPR_POS_GND = 2'h3;
  localparam logic [1:0] CMPR_POS_FIXED_REF = 2'h2;
  localparam logic [1:0] CMPR_POS_DAC = 2'h1;
  localparam logic [1:0] CMPR_POS_PIN = 2'h0;
  // Negative input select codes
  localparam logic [2:0] CMPR_NEG_GND = 3'h7;
  localparam logic [2:0] CMPR_NEG_FIXED_REF = 3'h6;
  localparam logic [2:0] CMPR_NEG_RSVD_HI = 3'h5;
  localparam logic [2:0] CMPR_NEG_RSVD_LO = 3'h4;

  typedef struct packed {
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic [1:0] pos_input_select;
    logic unused_bit;
    logic [2:0] neg_input_select;
  } cmpr_ctrl_s;

  // One-hot connection of the positive input node
  typedef struct packed {
    logic to_gnd;
    logic to_fixed_ref_voltage;
    logic to_dac;
    logic to_pin;
  } cmpr_pos_s;

  // Connection of the negative input node, one-hot except for the reserved codes, which leave it open
  typedef struct packed {
    logic to_gnd;
    logic to_fixed_ref_voltage;
    logic [3:0] to_pin;
  } cmpr_neg_s;
endpackage

/* File: hw/cmpr_edge_sync.sv */
// Three-stage synchroniser and edge detector for one comparator result
`timescale 1ns/1ps
module cmpr_edge_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Raw comparator result
  input wire logic i_async,
  // Filtered level and edge pulses
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only once stages two and three agree
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_level <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      o_rise <= (s2_q == s3_q) && s3_q && !o_level;
      o_fall <= (s2_q == s3_q) && !s3_q && o_level;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule

/* File: hw/cmpr_regs.sv */
// Comparator control, mirror and interrupt registers
`timescale 1ns/1ps
module cmpr_regs
  import cmpr_pkg::*;
#(
  parameter int N_CMP = CMPR_NUM
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port
  input wire logic [CMPR_ADDR_W-1:0] i_addr,
  input wire logic [CMPR_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [CMPR_DATA_W-1:0] o_rdata,
  // Comparator results from the analog cores
  input wire logic [N_CMP-1:0] i_cmp_result,
  // Input node connections to the analog cores
  output cmpr_pos_s [N_CMP-1:0] o_pos_sel,
  output cmpr_neg_s [N_CMP-1:0] o_neg_sel,
  // Interrupt
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check

  // Mirror register carries exactly two result bits
  if (N_CMP != 2) begin : g_bad_num
    $error("N_CMP must be 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-comparator logic

  cmpr_ctrl_s ctrl_q [N_CMP];
  logic [N_CMP-1:0] level;
  logic [N_CMP-1:0] rise;
  logic [N_CMP-1:0] fall;
  logic [N_CMP-1:0] irq_set;
  logic [N_CMP-1:0] status_q;
  logic [N_CMP-1:0] status_d;
  logic [N_CMP-1:0] mask_q;

  for (genvar i = 0; i < N_CMP; i++) begin : g_cmp
    logic ctrl_hit;
    assign ctrl_hit = i_addr == (CMPR_OFF_CTRL_BASE + 4'(i));

    cmpr_edge_sync u_sync (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_async(i_cmp_result[i]),
      .o_level(level[i]),
      .o_rise(rise[i]),
      .o_fall(fall[i])
    );

    // Unimplemented bit 3 never stores
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctrl_q[i] <= cmpr_ctrl_s'(CMPR_CTRL_RESET);
      end else if (i_wr && ctrl_hit) begin
        ctrl_q[i] <= cmpr_ctrl_s'(i_wdata & CMPR_CTRL_WMASK);
      end
    end

    assign irq_set[i] = (rise[i] && ctrl_q[i].rise_irq_enable)
                     || (fall[i] && ctrl_q[i].fall_irq_enable);

    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        o_pos_sel[i] <= '0;
      end else begin
        o_pos_sel[i].to_gnd <=
          ctrl_q[i].pos_input_select == CMPR_POS_GND;
        o_pos_sel[i].to_fixed_ref_voltage <=
          ctrl_q[i].pos_input_select == CMPR_POS_FIXED_REF;
        o_pos_sel[i].to_dac <=
          ctrl_q[i].pos_input_select == CMPR_POS_DAC;
        o_pos_sel[i].to_pin <=
          ctrl_q[i].pos_input_select == CMPR_POS_PIN;
      end
    end

    // negative input decode, reserved codes open
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        o_neg_sel[i] <= '0;
      end else begin
        o_neg_sel[i].to_gnd <=
          ctrl_q[i].neg_input_select == CMPR_NEG_GND;
        o_neg_sel[i].to_fixed_ref_voltage <=
          ctrl_q[i].neg_input_select == CMPR_NEG_FIXED_REF;
        o_neg_sel[i].to_pin <= ctrl_q[i].neg_input_select[2] ? 4'h0 :
          4'(4'h1 << ctrl_q[i].neg_input_select[1:0]);
      end
    end

    a_fall_sets_flag: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      fall[i] && ctrl_q[i].fall_irq_enable |=> status_q[i])
      else $error("enabled falling edge did not set flag");

    a_fall_masked_flag: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      fall[i] && !ctrl_q[i].fall_irq_enable && !status_q[i]
      |=> !status_q[i])
      else $error("disabled falling edge set flag");

    a_rise_sets_flag: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      rise[i] |=> status_q[i] == ($past(status_q[i])
        && !($past(i_wr) && $past(i_addr) == CMPR_OFF_IRQ_STATUS
             && $past(i_wdata[i]))
        || $past(ctrl_q[i].rise_irq_enable)))
      else $error("rising edge gating wrong");

    a_pos_decode_gnd: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      rst_n |=> o_pos_sel[i].to_gnd
        == ($past(ctrl_q[i].pos_input_select) == 2'h3)
      && $onehot(o_pos_sel[i]))
      else $error("positive select decode wrong");

    a_neg_decode_rsvd: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      rst_n |=> ($past(ctrl_q[i].neg_input_select[2:1]) == 2'h2)
        == (o_neg_sel[i] == '0))
      else $error("negative select reserved decode wrong");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask

  // Set wins over a write-one clear
  always_comb begin
    status_d = status_q;
    if (i_wr && i_addr == CMPR_OFF_IRQ_STATUS) begin
      status_d = status_q & ~i_wdata[N_CMP-1:0];
    end
    status_d = status_d | irq_set;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= '0;
    end else if (i_wr && i_addr == CMPR_OFF_IRQ_MASK) begin
      mask_q <= i_wdata[N_CMP-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [CMPR_DATA_W-1:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    if (i_addr == CMPR_OFF_CTRL_BASE) begin
      rdata_d = ctrl_q[0];
    end else if (i_addr == CMPR_OFF_CTRL_BASE + 4'h1) begin
      rdata_d = ctrl_q[1];
    end else if (i_addr == CMPR_OFF_MIRROR) begin
      rdata_d = CMPR_MIRROR_RESET | {6'h00, level[1], level[0]};
    end else if (i_addr == CMPR_OFF_IRQ_STATUS) begin
      rdata_d = {6'h00, status_q};
    end else if (i_addr == CMPR_OFF_IRQ_MASK) begin
      rdata_d = {6'h00, mask_q};
    end
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the read path and interrupt

  sequence s_mirror_read;
    i_rd && i_addr == CMPR_OFF_MIRROR;
  endsequence

  a_mirror_second_bit: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    s_mirror_read |=> o_rdata[1] == $past(level[1]))
    else $error("mirror bit 1 wrong");

  a_mirror_first_bit: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    s_mirror_read |=> o_rdata[0] == $past(level[0]))
    else $error("mirror bit 0 wrong");

  a_mirror_upper_zero: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    s_mirror_read |=> o_rdata[7:2] == 6'h00)
    else $error("mirror upper bits not zero");

  sequence s_flag_pending;
    (status_q & mask_q) != '0;
  endsequence

  a_irq_follows_flag: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_flag_pending ##1 s_flag_pending |-> o_irq)
    else $error("interrupt low with unmasked flag");

  a_read_one_cycle: assert property (@(posedge i_clk) disable iff (!rst_n)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside answer cycle");

  sequence s_status_write;
    i_wr && i_addr == CMPR_OFF_IRQ_STATUS;
  endsequence

  // Clear reaches every bit not set in that cycle
  a_flag_clears: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_status_write
    |=> (status_q & $past(i_wdata[N_CMP-1:0] & ~irq_set)) == '0)
    else $error("write-one clear left a flag set");

  // Set wins over a coincident clear
  a_flag_set_wins: assert property (@(posedge i_clk) disable iff (!rst_n)
    rst_n |=> (status_q & $past(irq_set)) == $past(irq_set))
    else $error("enabled edge lost to a clear");

  // Only an enabled edge raises a flag
  a_flag_set_cause: assert property (@(posedge i_clk) disable iff (!rst_n)
    rst_n |=> (status_q & ~$past(status_q) & ~$past(irq_set)) == '0)
    else $error("flag set without an enabled edge");

  // Flags hold while no clear is written
  a_flag_sticky: assert property (@(posedge i_clk) disable iff (!rst_n)
    !(i_wr && i_addr == CMPR_OFF_IRQ_STATUS)
    |=> (status_q & $past(status_q)) == $past(status_q))
    else $error("flag dropped without a clear");

  // Mask write lands in one cycle
  a_mask_write: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == CMPR_OFF_IRQ_MASK
    |=> mask_q == $past(i_wdata[N_CMP-1:0]))
    else $error("mask write did not land");

  // Bit 3 has no storage
  a_ctrl_write: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_wr && i_addr == CMPR_OFF_CTRL_BASE
    |=> CMPR_DATA_W'(ctrl_q[0]) == $past(i_wdata & CMPR_CTRL_WMASK))
    else $error("control write did not land");

  // Holes in the map read zero
  a_unmapped_zero: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_rd && i_addr > CMPR_OFF_IRQ_MASK |=> o_rdata == 8'h00)
    else $error("unmapped offset read nonzero");

  sequence s_flag_quiet;
    (status_q & mask_q) == '0 ##1 (status_q & $past(mask_q)) == '0;
  endsequence

  a_irq_quiet_low: assert property (@(posedge i_clk) disable iff (!rst_n)
    s_flag_quiet |-> !o_irq)
    else $error("interrupt high with no unmasked flag");
endmodule

/* File: dv/cmpr_core_model.sv */
// Behavioural analog comparator cores behind the input node selects
`timescale 1ns/1ps
module cmpr_core_model
  import cmpr_pkg::*;
#(
  parameter int FIXED_REF_MV = 100,
  parameter int DAC_MV = 50
) (
  // Input node connections
  input wire cmpr_pos_s [1:0] i_pos_sel,
  input wire cmpr_neg_s [1:0] i_neg_sel,
  // Pin voltages
  input wire logic [7:0] i_pos_pin [2],
  input wire logic [7:0] i_neg_pin [2][4],
  // Raw results
  output logic [1:0] o_result
);
  int vp [2];
  int vn [2];
  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      vp[c] = 0;
      if (i_pos_sel[c].to_fixed_ref_voltage) vp[c] = FIXED_REF_MV;
      if (i_pos_sel[c].to_dac) vp[c] = DAC_MV;
      if (i_pos_sel[c].to_pin) vp[c] = i_pos_pin[c];
      // negative node source
      // Unconnected node floats high, so the result is never high
      vn[c] = 255;
      if (i_neg_sel[c].to_gnd) vn[c] = 0;
      if (i_neg_sel[c].to_fixed_ref_voltage) vn[c] = FIXED_REF_MV;
      for (int k = 0; k < 4; k++) begin
        if (i_neg_sel[c].to_pin[k]) vn[c] = i_neg_pin[c][k];
      end
      o_result[c] = vp[c] > vn[c];
    end
  end
endmodule

/* File: dv/comparator_control_and_mirror_regs_tb_top.sv */
// Self-checking bench for the comparator register bank
`timescale 1ns/1ps
module comparator_control_and_mirror_regs_tb_top;
  import cmpr_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic [1:0] cmp_result;
  cmpr_pos_s [1:0] pos_sel;
  cmpr_neg_s [1:0] neg_sel;
  logic o_irq;
  logic [7:0] pos_pin [2] = '{8'h00, 8'h00};
  logic [7:0] neg_pin [2][4] = '{default: 8'h64};
  int miscompares = 0;
  int checks_done = 0;
  logic [7:0] d;

  always #2.5 i_clk = ~i_clk;

  cmpr_regs #(.N_CMP(2)) cmpr_regs_inst (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_result(cmp_result),
    .o_pos_sel(pos_sel), .o_neg_sel(neg_sel), .o_irq(o_irq));
  cmpr_core_model cmpr_core_model_inst (.i_pos_sel(pos_sel),
    .i_neg_sel(neg_sel), .i_pos_pin(pos_pin), .i_neg_pin(neg_pin),
    .o_result(cmp_result));
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Result change needs five edges to reach status
  task automatic settle();
    repeat (8) @(posedge i_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [3:0] a [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
    foreach (a[i]) begin
      rd(a[i]);
      chk(d, 8'h00);
    end
    chk({4'h0, pos_sel[0]}, 8'h01);
    chk({2'h0, neg_sel[1]}, 8'h01);
  endtask
  task automatic t_ctrl_rw();
    wr(4'h0, 8'hff);
    wr(4'h1, 8'h5a);
    rd(4'h0);
    chk(d, CMPR_CTRL_WMASK);
    rd(4'h1);
    chk(d, 8'h52);
  endtask
  task automatic t_decode();
    logic [7:0] e;
    for (int p = 0; p < 4; p++) begin
      wr(4'h0, 8'(p << 4));
      repeat (2) @(posedge i_clk);
      #1 chk({4'h0, pos_sel[0]}, 8'h01 << p);
    end
    for (int n = 0; n < 8; n++) begin
      wr(4'h1, 8'(n));
      repeat (2) @(posedge i_clk);
      e = (n == 4 || n == 5) ? 8'h00 : (n < 4) ? 8'h01 << n : 8'h01 << (n - 2);
      #1 chk({2'h0, neg_sel[1]}, e);
    end
  endtask
  task automatic t_mirror();
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h00);
    for (int v = 0; v < 4; v++) begin
      pos_pin[0] <= v[0] ? 8'hc8 : 8'h00;
      pos_pin[1] <= v[1] ? 8'hc8 : 8'h00;
      settle();
      wr(4'h2, 8'hff);
      rd(4'h2);
      chk(d, 8'(v));
    end
  endtask
  task automatic t_edges();
    pos_pin[0] <= 8'h00;
    pos_pin[1] <= 8'h00;
    settle();
    wr(4'h4, 8'h03);
    wr(4'h3, 8'h03);
    for (int e = 0; e < 4; e++) begin
      wr(4'h0, 8'(e << 6));
      pos_pin[0] <= 8'hc8;
      settle();
      rd(4'h3);
      chk(d, 8'(e >> 1));
      chk({7'h0, o_irq}, 8'(e >> 1));
      wr(4'h3, 8'h01);
      pos_pin[0] <= 8'h00;
      settle();
      rd(4'h3);
      chk(d, 8'(e & 1));
      wr(4'h3, 8'h01);
    end
    wr(4'h4, 8'h01);
    wr(4'h1, 8'h80);
    pos_pin[1] <= 8'hc8;
    settle();
    rd(4'h3);
    chk(d, 8'h02);
    chk({7'h0, o_irq}, 8'h00);
    wr(4'h4, 8'h03);
    settle();
    chk({7'h0, o_irq}, 8'h01);
    wr(4'h3, 8'h02);
    settle();
    chk({7'h0, o_irq}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    t_reset();
    t_ctrl_rw();
    t_decode();
    t_mirror();
    t_edges();
    wrap_up();
  end
  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
endmodule
